// ==== src/drb_diag_record_builder.sv ====
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
module drb_diag_record_builder #(
   parameter int NUM_DI  = drb_pkg::NUM_DI,
   parameter int NUM_CNT = drb_pkg::NUM_CNT
) (
   input  wire logic                                        clk,
   input  wire logic                                        rst,
   input  wire logic                                        ce,
   input  wire logic [drb_pkg::ADDR_W-1:0]                  reg_addr,
   input  wire logic [drb_pkg::DATA_W-1:0]                  reg_wdata,
   input  wire logic                                        reg_wr,
   input  wire logic                                        reg_rd,
   output      logic [drb_pkg::DATA_W-1:0]                  reg_rdata,
   input  wire logic [NUM_DI-1:0]                           di_pi_req,
   input  wire logic [NUM_DI-1:0]                           di_pi_done,
   input  wire logic [NUM_CNT*drb_pkg::CNT_EVT-1:0]         cnt_pi_req,
   input  wire logic [NUM_CNT*drb_pkg::CNT_EVT-1:0]         cnt_pi_done,
   input  wire logic                                        mod_fail,
   input  wire logic                                        ext_fault,
   input  wire logic                                        chan_fault,
   output      logic                                        diag_in_pulse,
   output      logic                                        diag_out_pulse,
   output      logic                                        irq
);

   localparam int NCE = NUM_CNT * drb_pkg::CNT_EVT;
   localparam int NEV = NUM_DI + NCE;

   // The record layout has fixed byte positions, so only the documented sizes fit.
   if (NUM_DI != drb_pkg::NUM_DI) begin
      $error("drb_diag_record_builder: record layout needs 16 inputs");
   end
   if (NUM_CNT != drb_pkg::NUM_CNT) begin
      $error("drb_diag_record_builder: record layout needs 3 counters");
   end

   // ==========================================================================
   // Helpers
   // ==========================================================================

   // Places four flags on bit positions 0, 2, 4 and 6.
   function automatic logic [7:0] spread4(input logic [3:0] f);
      spread4 = {1'b0, f[3], 1'b0, f[2], 1'b0, f[1], 1'b0, f[0]};
   endfunction

   // A write strobe aimed at one register offset.
   function automatic logic wr_hit(input logic                        wr,
                                   input logic [drb_pkg::ADDR_W-1:0] addr,
                                   input logic [drb_pkg::ADDR_W-1:0] ofs);
      wr_hit = wr && addr == ofs;
   endfunction

   // ==========================================================================
   // Fault level synchronisers
   // ==========================================================================

   // The fault levels come from the field side, outside this clock's domain.
   // A change is taken only once the second and third stages agree, so a level
   // caught mid-transition never reaches a snapshot. The cost is four cycles of
   // latency: a fault must settle that long before an event to be captured.
   logic [2:0] flt_pin;
   logic [2:0] flt_s1_r;
   logic [2:0] flt_s2_r;
   logic [2:0] flt_s3_r;
   logic [2:0] flt_agree;
   logic [2:0] flt_r;

   assign flt_pin   = {chan_fault, ext_fault, mod_fail};
   assign flt_agree = ~(flt_s2_r ^ flt_s3_r);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flt_s1_r <= '0;
         flt_s2_r <= '0;
         flt_s3_r <= '0;
      end else if (ce) begin
         flt_s1_r <= flt_pin;
         flt_s2_r <= flt_s1_r;
         flt_s3_r <= flt_s2_r;
      end
   end

   // Each bit is filtered alone, so one settling fault does not hold back the others.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flt_r <= '0;
      end else if (ce) begin
         flt_r <= (flt_s3_r & flt_agree) | (flt_r & ~flt_agree);
      end
   end

   // ==========================================================================
   // Process interrupt tracking
   // ==========================================================================

   logic [NEV-1:0] req_all;
   logic [NEV-1:0] done_all;
   logic [NEV-1:0] busy_r;
   logic [NEV-1:0] lost_r;
   logic [NEV-1:0] lost_nxt;
   logic [NEV-1:0] loss_now;
   logic           lost_any_r;

   assign req_all  = {cnt_pi_req, di_pi_req};
   assign done_all = {cnt_pi_done, di_pi_done};

   // loss detection
   // A request that meets a still-busy event is a loss; a done in the same
   // cycle frees the event first, so the new request is then served normally.
   assign loss_now = req_all & busy_r & ~done_all;

   // A done clears the loss flag; a request in the same cycle as its done is no loss.
   assign lost_nxt = loss_now | (lost_r & ~done_all);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         busy_r <= '0;
      end else if (ce) begin
         busy_r <= req_all | (busy_r & ~done_all);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lost_r     <= '0;
         lost_any_r <= 1'b0;
      end else if (ce) begin
         lost_r     <= lost_nxt;
         lost_any_r <= |lost_nxt;
      end
   end

   // ==========================================================================
   // Registers
   // ==========================================================================

   logic [drb_pkg::CTRL_W-1:0] ctrl_r;
   logic [drb_pkg::ST_W-1:0]   stat_r;
   logic [drb_pkg::ST_W-1:0]   mask_r;
   logic                       diag_en;
   logic                       ev_in;
   logic                       ev_out;

   assign diag_en = ctrl_r[drb_pkg::CTRL_DIAG_EN];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_r <= drb_pkg::CTRL_RST;
      end else if (ce && wr_hit(reg_wr, reg_addr, drb_pkg::OFS_CTRL)) begin
         ctrl_r <= reg_wdata[drb_pkg::CTRL_W-1:0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mask_r <= drb_pkg::ST_RST;
      end else if (ce && wr_hit(reg_wr, reg_addr, drb_pkg::OFS_MASK)) begin
         mask_r <= reg_wdata[drb_pkg::ST_W-1:0];
      end
   end

   // ==========================================================================
   // Diagnostic events
   // ==========================================================================

   assign ev_in = |loss_now;

   // outgoing when cleared
   // The last pending loss being handled ends the condition; the message is
   // only given while the diagnostic interrupt stays enabled.
   assign ev_out = lost_any_r && !(|lost_nxt) && diag_en;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         diag_in_pulse  <= 1'b0;
         diag_out_pulse <= 1'b0;
      end else if (ce) begin
         diag_in_pulse  <= ev_in && diag_en;
         diag_out_pulse <= ev_out;
      end else begin
         diag_in_pulse  <= 1'b0;
         diag_out_pulse <= 1'b0;
      end
   end

   // Sticky status, write one to clear; a new event wins over the clear.
   logic [drb_pkg::ST_W-1:0] st_set;
   logic [drb_pkg::ST_W-1:0] st_clr;

   always_comb begin
      st_set = '0;
      st_set[drb_pkg::ST_INCOMING] = ev_in && diag_en;
      st_set[drb_pkg::ST_OUTGOING] = ev_out;
      st_clr = '0;
      if (wr_hit(reg_wr, reg_addr, drb_pkg::OFS_STAT)) begin
         st_clr = reg_wdata[drb_pkg::ST_W-1:0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stat_r <= drb_pkg::ST_RST;
      end else if (ce) begin
         stat_r <= st_set | (stat_r & ~st_clr);
      end
   end

   assign irq = |(stat_r & mask_r);

   // ==========================================================================
   // Record assembly
   // ==========================================================================

   drb_pkg::drb_ext_s rec_nxt;
   drb_pkg::drb_ext_s rec_r;
   logic              rec_inc_r;

   always_comb begin
      rec_nxt = '0;
      // shared basic layout
      // The basic record is built the same way whatever technology function runs.
      // byte 0 faults
      rec_nxt.basic.b0[0] = flt_r[0];
      rec_nxt.basic.b0[2] = flt_r[1];
      rec_nxt.basic.b0[3] = flt_r[2] | ev_in | (|lost_nxt);
      rec_nxt.basic.b1[3:0] = ctrl_r[drb_pkg::CTRL_ANALOG] ? drb_pkg::CLASS_ANALOG : drb_pkg::CLASS_DIGITAL;
      rec_nxt.basic.b1[4]   = ctrl_r[drb_pkg::CTRL_CH_INFO];
      // incoming lost flag
      // Byte 2 stays zero in both forms; byte 3 carries the loss only when incoming.
      rec_nxt.basic.b2 = 8'h00;
      rec_nxt.basic.b3[drb_pkg::B3_PI_LOST] = ev_in;
      rec_nxt.fn[0] = {ctrl_r[drb_pkg::CTRL_MORE_TYP], drb_pkg::CHT_DIG_IN};
      rec_nxt.fn[1] = drb_pkg::BITS_PER_CH;
      rec_nxt.fn[2] = drb_pkg::CH_PER_MOD;
      for (int g = 0; g < 4; g++) begin
         rec_nxt.fn[3][g] = |lost_nxt[g*4 +: 4];
      end
      for (int c = 0; c < NUM_CNT; c++) begin
         rec_nxt.fn[3][4+c] = |lost_nxt[NUM_DI + c*4 +: 4];
      end
      rec_nxt.fn[3][7] = 1'b0;
      for (int k = 0; k < 4; k++) begin
         rec_nxt.fn[4+k] = spread4(lost_nxt[k*4 +: 4]);
      end
      // counter loss bytes
      // Event order per counter: gate closed, gate opened, over/underflow, compare.
      for (int c = 0; c < NUM_CNT; c++) begin
         rec_nxt.fn[8+c] = spread4(lost_nxt[NUM_DI + c*4 +: 4]);
      end
      rec_nxt.fn[11] = 8'h00;
   end

   // snapshot capture
   // Only outgoing capture is gated by the enable, so with diagnostics off software can
   // still read the latest incoming loss; incoming wins if both would fire at once.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rec_r     <= '0;
         rec_inc_r <= 1'b0;
      end else if (ce && (ev_in || ev_out)) begin
         rec_r     <= rec_nxt;
         rec_inc_r <= ev_in;
      end
   end

   // ==========================================================================
   // Register read port
   // ==========================================================================

   logic [drb_pkg::DATA_W-1:0] rd_nxt;

   always_comb begin
      rd_nxt = '0;
      unique case (reg_addr)
         drb_pkg::OFS_REC0: rd_nxt = rec_r[31:0];
         drb_pkg::OFS_REC1: rd_nxt = rec_r[63:32];
         drb_pkg::OFS_REC2: rd_nxt = rec_r[95:64];
         drb_pkg::OFS_REC3: rd_nxt = rec_r[127:96];
         drb_pkg::OFS_CTRL: rd_nxt[drb_pkg::CTRL_W-1:0] = ctrl_r;
         drb_pkg::OFS_STAT: rd_nxt[drb_pkg::ST_W-1:0] = stat_r;
         drb_pkg::OFS_MASK: rd_nxt[drb_pkg::ST_W-1:0] = mask_r;
         drb_pkg::OFS_LIVE: begin
            rd_nxt[NEV-1:0] = lost_r;
            rd_nxt[drb_pkg::LIVE_INC_BIT] = rec_inc_r;
         end
         default: rd_nxt = '0;
      endcase
   end

   // Data stand from the enabled edge that takes the read strobe until the next enabled edge.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= '0;
      end else if (ce) begin
         reg_rdata <= reg_rd ? rd_nxt : '0;
      end
   end

endmodule

// ==== src/drb_pkg.sv ====
// Behaviour
// - After the loss condition clears, report outgoing only while diagnostics are enabled.
// - Basic byte 0: bit0 module failure, bit2 external fault, bit3 channel fault.
// - Basic byte 1: module class in bits 3..0, bit4 channel info present.
// - Outgoing basic record returns bytes 2 and 3 as zero.
// - Basic record layout is the same for every technology function.
// - Extended record is the 4 basic bytes plus 12 function bytes.
// - Byte 4 holds channel type digital input, bit7 more types present.
// - Byte 5 reports eight diagnostic bits per channel.
// - Byte 6 reports eight channels per module.
// - Byte 7 flags four input groups, three counters, bit7 reserved.
// - Bytes 12..14 flag lost counter events on even bits.
// - A new process interrupt while the previous is handled raises a diagnostic.
// - Incoming basic record sets byte 3 bit 6 for a lost interrupt.
package drb_pkg;

   localparam int        ADDR_W        = 8;
   localparam int        DATA_W        = 32;
   localparam int        NUM_DI        = 16;
   localparam int        NUM_CNT       = 3;
   localparam int        CNT_EVT       = 4;

   // Register offsets.
   localparam logic [7:0] OFS_REC0     = 8'h00;
   localparam logic [7:0] OFS_REC1     = 8'h04;
   localparam logic [7:0] OFS_REC2     = 8'h08;
   localparam logic [7:0] OFS_REC3     = 8'h0C;
   localparam logic [7:0] OFS_CTRL     = 8'h10;
   localparam logic [7:0] OFS_STAT     = 8'h14;
   localparam logic [7:0] OFS_MASK     = 8'h18;
   localparam logic [7:0] OFS_LIVE     = 8'h1C;

   // Control fields and reset value.
   localparam int        CTRL_DIAG_EN  = 0;
   localparam int        CTRL_CH_INFO  = 1;
   localparam int        CTRL_MORE_TYP = 2;
   localparam int        CTRL_ANALOG   = 3;
   localparam int        CTRL_W        = 4;
   localparam logic [3:0] CTRL_RST     = 4'h0;

   // Status and mask fields.
   localparam int        ST_INCOMING   = 0;
   localparam int        ST_OUTGOING   = 1;
   localparam int        ST_W          = 2;
   localparam logic [1:0] ST_RST       = 2'h0;
   localparam int        LIVE_INC_BIT  = 31;

   // Record contents.
   localparam logic [3:0] CLASS_ANALOG  = 4'h5;
   localparam logic [3:0] CLASS_DIGITAL = 4'hF;
   localparam logic [6:0] CHT_DIG_IN    = 7'h70;
   localparam logic [6:0] CHT_ANA_IN    = 7'h71;
   localparam logic [6:0] CHT_DIG_OUT   = 7'h72;
   localparam logic [6:0] CHT_ANA_OUT   = 7'h73;
   localparam logic [6:0] CHT_ANA_IO    = 7'h74;
   localparam logic [7:0] BITS_PER_CH   = 8'h08;
   localparam logic [7:0] CH_PER_MOD    = 8'h08;
   localparam int        B3_PI_LOST    = 6;

   typedef struct packed {
      logic [7:0] b3;
      logic [7:0] b2;
      logic [7:0] b1;
      logic [7:0] b0;
   } drb_basic_s;

   // Function byte k sits at record byte k + 4.
   typedef struct packed {
      logic [11:0][7:0] fn;
      drb_basic_s       basic;
   } drb_ext_s;

endpackage

// ==== test/drb_diag_record_builder_asserts.sv ====
`timescale 1ns/100ps
module drb_diag_record_builder_asserts #(
   parameter int NUM_DI  = 16,
   parameter int NUM_CNT = 3
) (
   input wire logic                                clk,
   input wire logic                                rst,
   input wire logic                                ce,
   input wire logic [drb_pkg::ADDR_W-1:0]          reg_addr,
   input wire logic                                reg_rd,
   input wire logic [drb_pkg::DATA_W-1:0]          reg_rdata,
   input wire logic [NUM_DI-1:0]                   di_pi_req,
   input wire logic [NUM_DI-1:0]                   di_pi_done,
   input wire logic [NUM_CNT*drb_pkg::CNT_EVT-1:0] cnt_pi_req,
   input wire logic [NUM_CNT*drb_pkg::CNT_EVT-1:0] cnt_pi_done,
   input wire logic                                diag_in_pulse,
   input wire logic                                diag_out_pulse
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic rd0, rd1, rd2, rd3;
   assign rd0 = reg_rd && ce && reg_addr == drb_pkg::OFS_REC0;
   assign rd1 = reg_rd && ce && reg_addr == drb_pkg::OFS_REC1;
   assign rd2 = reg_rd && ce && reg_addr == drb_pkg::OFS_REC2;
   assign rd3 = reg_rd && ce && reg_addr == drb_pkg::OFS_REC3;
   // ==========================================================
   // Record fields and event causes
   in_cause_a: assert property (diag_in_pulse |-> $past(|{di_pi_req, cnt_pi_req}))
      else $error("incoming pulse without a request");
   out_cause_a: assert property (diag_out_pulse |-> $past(|{di_pi_done, cnt_pi_done}))
      else $error("outgoing pulse without a completion");
   one_dir_a: assert property (!(diag_in_pulse && diag_out_pulse))
      else $error("both pulses together");
   fixed_zero_a: assert property (rd0 |=> (reg_rdata & 32'h00FFE0F2) == 32'h0)
      else $error("fixed zero bits set in word 0");
   b3_form_a: assert property (rd0 |=> reg_rdata[31:24] inside {8'h00, 8'h40})
      else $error("byte 3 malformed");
   desc_bytes_a: assert property (rd1 |=> (reg_rdata[23:0] & 24'hFFFF7F) == 24'h080870)
      else $error("descriptor bytes wrong");
   group_resv_a: assert property (rd1 |=> !reg_rdata[31])
      else $error("reserved group bit set");
   in_even_a: assert property (rd2 |=> (reg_rdata & 32'hAAAAAAAA) == 32'h0)
      else $error("odd input bit set");
   cnt_even_a: assert property (rd3 |=> (reg_rdata & 32'hFFAAAAAA) == 32'h0)
      else $error("odd counter bit set");
endmodule
bind drb_diag_record_builder drb_diag_record_builder_asserts #(.NUM_DI(NUM_DI), .NUM_CNT(NUM_CNT))
   drb_diag_record_builder_asserts_inst (.clk, .rst, .ce, .reg_addr, .reg_rd, .reg_rdata, .di_pi_req,
   .di_pi_done, .cnt_pi_req, .cnt_pi_done, .diag_in_pulse, .diag_out_pulse);

// ==== test/drb_diag_record_builder_tb_top.sv ====
`timescale 1ns/100ps
module drb_diag_record_builder_tb_top;
   logic        clk = 0, rst = 1, ce = 1, reg_wr = 0, reg_rd = 0;
   logic [7:0]  reg_addr = 8'h00, lat = 8'h14;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
   logic [27:0] req = 28'h0, done;
   logic [2:0]  flt = 3'h0;
   logic [3:0]  cfg;
   logic        diag_in_pulse, diag_out_pulse, irq;
   int          fails = 0, checked = 0, cyc = 0, idx;
   int          corner [4] = '{0, 15, 16, 27};
   always #4 clk = ~clk;
   drb_diag_record_builder drb_diag_record_builder_inst (.clk, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .di_pi_req(req[15:0]), .di_pi_done(done[15:0]), .cnt_pi_req(req[27:16]),
      .cnt_pi_done(done[27:16]), .mod_fail(flt[0]), .ext_fault(flt[1]), .chan_fault(flt[2]),
      .diag_in_pulse, .diag_out_pulse, .irq);
   drb_handler_model drb_handler_model_inst (.clk, .rst, .lat, .req, .done);
   // ==========================================================
   // Helpers
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         end_of_test();
      end
   end
   task automatic chk(string n, logic [31:0] x, logic [31:0] g);
      checked++;
      if (g !== x) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'h1;
      @(posedge clk);
      reg_wr <= 1'h0;
      @(posedge clk);
   endtask
   task automatic rd(logic [7:0] a);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clk);
      reg_rd <= 1'h0;
      @(posedge clk);
      d = reg_rdata;
   endtask
   // Lost flags map to group bit i/4 and to function byte 4+i/4 for inputs and counters alike.
   function automatic drb_pkg::drb_ext_s exp_rec(logic [27:0] lost, logic inc);
      drb_pkg::drb_ext_s r;
      r = '0;
      r.basic.b0 = {4'h0, flt[2] | (|lost), flt[1], 1'h0, flt[0]};
      r.basic.b1 = {3'h0, cfg[1], cfg[3] ? drb_pkg::CLASS_ANALOG : drb_pkg::CLASS_DIGITAL};
      r.basic.b3 = inc ? 8'h40 : 8'h00;
      r.fn[0] = {cfg[2], drb_pkg::CHT_DIG_IN};
      r.fn[1] = drb_pkg::BITS_PER_CH;
      r.fn[2] = drb_pkg::CH_PER_MOD;
      for (int i = 0; i < 28; i++) begin
         if (lost[i]) begin
            r.fn[3][i / 4] = 1'h1;
            r.fn[4 + i / 4][2 * (i % 4)] = 1'h1;
         end
      end
      return r;
   endfunction
   task automatic chk_rec(drb_pkg::drb_ext_s x);
      for (int n = 0; n < 4; n++) begin
         rd(8'(4 * n));
         chk("record word", x[32 * n +: 32], d);
      end
   endtask
   // The wait ends early on the pulse, so a pulse is never confused with a later one.
   task automatic see(logic sel, logic want);
      logic s;
      s = 1'h0;
      for (int t = 0; t < 60 && !s; t++) begin
         @(posedge clk);
         s = sel ? diag_out_pulse : diag_in_pulse;
      end
      chk(sel ? "outgoing pulse" : "incoming pulse", {31'h0, want}, {31'h0, s});
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      void'($urandom(69));
      repeat (5) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      for (int a = 16; a <= 32; a += 4) begin
         rd(8'(a));
         chk("reset or unmapped", 32'h0, d);
      end
      // With the clock enable low a write must not land.
      ce <= 1'h0;
      wr(drb_pkg::OFS_MASK, 32'h3);
      ce <= 1'h1;
      rd(drb_pkg::OFS_MASK);
      chk("mask while frozen", 32'h0, d);
      cfg = 4'($urandom) | 4'h1;
      wr(drb_pkg::OFS_CTRL, {28'h0, cfg});
      for (int k = 0; k < 8; k++) begin
         idx = k < 4 ? corner[k] : $urandom_range(27);
         flt <= 3'($urandom);
         lat <= (k % 2 == 1) ? 8'h30 : 8'h14;
         wr(drb_pkg::OFS_MASK, k == 6 ? 32'h0 : 32'h3);
         req <= 28'h1 << idx;
         @(posedge clk);
         req <= 28'h0;
         @(posedge clk);
         req <= 28'h1 << idx;
         @(posedge clk);
         req <= 28'h0;
         see(1'h0, 1'h1);
         chk("interrupt", {31'h0, k != 6}, {31'h0, irq});
         chk_rec(exp_rec(28'h1 << idx, 1'h1));
         rd(drb_pkg::OFS_LIVE);
         chk("live flags", {1'h1, 3'h0, 28'h1 << idx}, d);
         if (k == 7) wr(drb_pkg::OFS_CTRL, {28'h0, cfg & 4'hE});
         see(1'h1, k != 7);
         if (k != 7) chk_rec(exp_rec(28'h0, 1'h0));
         rd(drb_pkg::OFS_STAT);
         chk("status", {30'h0, k != 7, 1'h1}, d);
         wr(drb_pkg::OFS_STAT, 32'h3);
         rd(drb_pkg::OFS_STAT);
         chk("status cleared", 32'h0, d);
         chk("interrupt cleared", 32'h0, {31'h0, irq});
      end
      // A second reset must wipe the record and flags left by the last loss.
      rst <= 1'h1;
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      rd(drb_pkg::OFS_LIVE);
      chk("live after reset", 32'h0, d);
      rd(drb_pkg::OFS_REC0);
      chk("record after reset", 32'h0, d);
      end_of_test();
   end
endmodule

// ==== test/drb_handler_model.sv ====
`timescale 1ns/100ps
module drb_handler_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [7:0]  lat,
   input  wire logic [27:0] req,
   output      logic [27:0] done
);
   logic [7:0] cnt_r [28];
   // A request while an event is still handled is dropped, as the real handler does not queue it.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         done <= 28'h0;
         cnt_r <= '{default: 8'h00};
      end else begin
         for (int i = 0; i < 28; i++) begin
            done[i] <= cnt_r[i] == 8'h01;
            if (cnt_r[i] != 8'h00) begin
               cnt_r[i] <= cnt_r[i] - 8'h01;
            end else if (req[i]) begin
               cnt_r[i] <= lat;
            end
         end
      end
   end
endmodule
